// *** adc_roundrobin_margin_dac_tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module adc_roundrobin_margin_dac_tb_top;
  import armd_pkg::*;
  typedef struct {logic [7:0] a; logic [31:0] d;} armd_row_t;
  logic          clk = 1'b0, resetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, engineRunReq = 1'b0;
  logic [31:0]   haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0]    htrans = 2'h0;
  logic [2:0]    hsize = 3'h2, adcChannel;
  logic          hreadyout, hresp, adcStart, busy, irq;
  logic [11:0]   adcData;
  logic [7:0]    engineWarn;
  armd_dac_out_t [3:0] dacOut;
  int            mismatches = 0, nTests = 0, cycles = 0;
  armd_row_t     rows [9] = '{'{8'h00, 32'h0}, '{8'h04, 32'h0}, '{8'h08, 32'h0},
    '{8'h0C, 32'h0}, '{8'h10, 32'h0}, '{8'h14, 32'h0}, '{8'h60, 32'h7F},
    '{8'h70, 32'h00FF0000}, '{8'h80, 32'h0}};

  armd_top #(.CONV_CYCLES(8), .TRACK_CYCLES(9)) DUT (.clk(clk), .resetn(resetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .adcChannel(adcChannel), .adcStart(adcStart), .adcData(adcData),
    .engineRunReq(engineRunReq), .engineWarn(engineWarn), .busy(busy), .irq(irq),
    .dacOut(dacOut));
  armd_adc_model adcModel (.clk(clk), .resetn(resetn), .adcChannel(adcChannel),
    .adcStart(adcStart), .adcData(adcData));

  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    hsel <= 1'b1;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nTests++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdChk
  task automatic waitIdle;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 3000 && busy !== 1'b0; i++) @(posedge clk);
  endtask : waitIdle
  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", nTests, mismatches);
    if (mismatches == 0 && nTests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : complete_run

  initial forever #25 clk = ~clk;
  // Ceiling well above the few hundred cycles the sequence needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      complete_run();
    end
  end

  initial begin
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    foreach (rows[i]) rdChk(rows[i].a, rows[i].d);
    bus(1'b1, 8'h04, 32'h05);
    bus(1'b1, 8'h08, 32'h01);
    bus(1'b1, 8'h20, 32'h008);
    bus(1'b1, 8'h28, 32'h100);
    bus(1'b1, 8'h14, 32'h3);
    bus(1'b1, 8'h00, 32'h1);
    waitIdle();
    rdChk(8'h40, 32'h010);
    rdChk(8'h48, 32'h210);
    rdChk(8'h44, 32'h0);
    rdChk(8'h00, 32'h0);
    rdChk(8'h0C, 32'h01);
    chk({24'h0, engineWarn}, 32'h01);
    chk({31'h0, irq}, 32'h1);
    bus(1'b1, 8'h14, 32'h0);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    bus(1'b1, 8'h14, 32'h3);
    bus(1'b1, 8'h10, 32'h3);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    // Averaged run on channel 1: result must stay old until all 16 passes end
    bus(1'b1, 8'h04, 32'h02);
    bus(1'b1, 8'h00, 32'h5);
    repeat (60) @(posedge clk);
    chk({31'h0, busy}, 32'h1);
    rdChk(8'h44, 32'h0);
    waitIdle();
    rdChk(8'h44, 32'h110);
    bus(1'b1, 8'h00, 32'h2);
    engineRunReq <= 1'b1;
    repeat (100) @(posedge clk);
    chk({31'h0, busy}, 32'h1);
    bus(1'b1, 8'h00, 32'h0);
    engineRunReq <= 1'b0;
    waitIdle();
    chk({31'h0, busy}, 32'h0);
    // Margin DAC 1: clamp, offset from midcode, track then drive
    bus(1'b1, 8'h64, 32'hF0);
    bus(1'b1, 8'h74, 32'h00802006);
    repeat (3) @(posedge clk);
    chk({30'h0, dacOut[1].bufPower, dacOut[1].bufToDac | dacOut[1].stageOn}, 32'h2);
    repeat (10) @(posedge clk);
    chk({30'h0, dacOut[1].bufToDac, dacOut[1].stageOn}, 32'h3);
    chk({24'h0, dacOut[1].code}, 32'h80);
    chk({23'h0, dacOut[1].offset}, 32'h001);
    chk({30'h0, dacOut[1].range}, 32'h2);
    chk({24'h0, dacOut[0].code}, 32'h7F);
    bus(1'b1, 8'h64, 32'h10);
    repeat (3) @(posedge clk);
    chk({24'h0, dacOut[1].code}, 32'h20);
    chk({23'h0, dacOut[1].offset}, 32'h1A1);
    bus(1'b1, 8'h74, 32'h00809006);
    repeat (3) @(posedge clk);
    chk({31'h0, dacOut[1].stageOn}, 32'h0);
    // Reset in mid-loop: sequencer and stages drop at once, results clear
    bus(1'b1, 8'h00, 32'h1);
    repeat (5) @(posedge clk);
    chk({31'h0, busy}, 32'h1);
    resetn <= 1'b0;
    @(posedge clk);
    chk({30'h0, busy, dacOut[1].bufPower}, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    resetn <= 1'b1;
    @(posedge clk);
    rdChk(8'h44, 32'h0);
    rdChk(8'h04, 32'h0);
    complete_run();
  end
endmodule : adc_roundrobin_margin_dac_tb_top
`default_nettype wire

// *** armd_adc_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module armd_adc_model (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [2:0]  adcChannel,
  input  wire logic        adcStart,
  output var  logic [11:0] adcData
);
  logic [2:0] chReg;
  // Channel latched at slot start so a late channel change cannot alter the slot's code
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) chReg <= 3'h0;
    else if (adcStart) chReg <= adcChannel;
  end
  assign adcData = {1'b0, chReg, 8'h10};
endmodule : armd_adc_model
`default_nettype wire

// *** armd_dac_chan.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "armd_defines.svh"

module armd_dac_chan #(
  parameter int TRACK_CYCLES = `ARMD_TRACK_CYCLES
) (
  input  wire logic                    clk,
  input  wire logic                    resetn,
  input  wire logic [7:0]              code,
  input  wire armd_pkg::armd_dac_cfg_t cfg,
  output var  armd_pkg::armd_dac_out_t dacOut
);
  import armd_pkg::*;

  localparam int TW = $clog2(TRACK_CYCLES + 1);

  armd_dac_state_t state_reg;
  logic [TW-1:0]   timer_reg;
  logic [7:0]      clamped;
  logic            badLimits;

  assign badLimits = cfg.lower > cfg.upper;
  always_comb begin
    clamped = code;
    if (code < cfg.lower) begin
      clamped = cfg.lower;
    end else if (code > cfg.upper) begin
      clamped = cfg.upper;
    end
  end

  // ----------------------------------------
  // Glitch-free enable: track pin, then drive
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= DAC_OFF;
      timer_reg <= '0;
    end else begin
      unique case (state_reg)
        DAC_OFF: begin
          timer_reg <= '0;
          if (cfg.en) state_reg <= DAC_TRACK;
        end
        DAC_TRACK: begin
          timer_reg <= timer_reg + 1'b1;
          if (!cfg.en) begin
            state_reg <= DAC_OFF;
          end else if (timer_reg == TW'(TRACK_CYCLES - 1)) begin
            state_reg <= DAC_DRIVE;
          end
        end
        DAC_DRIVE: begin
          if (!cfg.en) state_reg <= DAC_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dacOut <= '0;
    end else begin
      dacOut.code     <= clamped;
      // Midcode 0x7F leaves 128 steps above and 127 below
      dacOut.offset   <= $signed({1'b0, clamped}) - $signed({1'b0, `ARMD_DAC_MID});
      dacOut.range    <= cfg.range;
      dacOut.bufPower <= state_reg != DAC_OFF;
      dacOut.bufToDac <= state_reg == DAC_DRIVE;
      // Crossed limits keep the stage off so firmware slips cannot drive
      dacOut.stageOn  <= (state_reg == DAC_DRIVE) && !badLimits;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_tracking;
    dacOut.bufPower && !dacOut.bufToDac;
  endsequence
  sequence s_driving;
    dacOut.bufToDac;
  endsequence

  a_track_then_drive: assert property (
    $rose(dacOut.bufToDac) |-> $past(dacOut.bufPower && !dacOut.bufToDac))
    else $error("dac drove without tracking first");
  a_track_length: assert property (
    $rose(dacOut.bufPower) && cfg.en |-> s_tracking[*8])
    else $error("dac tracking phase too short");
  a_clamp_window: assert property (
    !$past(badLimits)
      |-> dacOut.code >= $past(cfg.lower) && dacOut.code <= $past(cfg.upper))
    else $error("dac code outside clamp window");
  a_hiz_crossed: assert property (
    $past(badLimits) |-> !dacOut.stageOn)
    else $error("dac stage on with crossed limits");
  a_offset_mid: assert property (
    s_driving |-> dacOut.offset == $signed({1'b0, dacOut.code}) - 9'sh07F)
    else $error("dac offset not relative to midcode");

endmodule : armd_dac_chan

`default_nettype wire

// *** armd_defines.svh ***
`ifndef ARMD_DEFINES_SVH
`define ARMD_DEFINES_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define ARMD_CLK_MHZ        20
`define ARMD_CONV_TIME_US   500
`define ARMD_CONV_CYCLES    (`ARMD_CONV_TIME_US * `ARMD_CLK_MHZ)
`define ARMD_TRACK_TIME_US  10
`define ARMD_TRACK_CYCLES   (`ARMD_TRACK_TIME_US * `ARMD_CLK_MHZ)
`define ARMD_AVG_LAST_PASS  4'hF
`define ARMD_CHANNELS       8
`define ARMD_DACS           4

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define ARMD_OFF_CTRL       8'h00
`define ARMD_OFF_CHSEL      8'h04
`define ARMD_OFF_LIMDIR     8'h08
`define ARMD_OFF_STATUS     8'h0C
`define ARMD_OFF_IRQSTAT    8'h10
`define ARMD_OFF_IRQMASK    8'h14
`define ARMD_OFF_LIMIT      8'h20
`define ARMD_OFF_RESULT     8'h40
`define ARMD_OFF_DACCODE    8'h60
`define ARMD_OFF_DACCFG     8'h70
`define ARMD_BANK8_MASK     8'hE0
`define ARMD_BANK4_MASK     8'hF0

// ----------------------------------------
// Field positions
// ----------------------------------------
`define ARMD_CTRL_RUN       0
`define ARMD_CTRL_CONT      1
`define ARMD_CTRL_AVG       2
`define ARMD_STAT_BUSY      8
`define ARMD_IRQ_DONE       0
`define ARMD_IRQ_WARN       1
`define ARMD_CFG_RANGE      0
`define ARMD_CFG_EN         2
`define ARMD_CFG_LO         8
`define ARMD_CFG_HI         16

// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define ARMD_DAC_MID        8'h7F
`define ARMD_DAC_CODE_RST   8'h7F
`define ARMD_DAC_LO_RST     8'h00
`define ARMD_DAC_HI_RST     8'hFF
`define ARMD_LIMIT_RST      12'h000

`endif

// *** armd_pkg.sv ***
package armd_pkg;

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_CONVERT,
    SEQ_PUBLISH
  } armd_seq_state_t;

  typedef enum logic [1:0] {
    DAC_OFF,
    DAC_TRACK,
    DAC_DRIVE
  } armd_dac_state_t;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
  } armd_addr_phase_t;

  typedef struct packed {
    logic [7:0] upper;
    logic [7:0] lower;
    logic       en;
    logic [1:0] range;
  } armd_dac_cfg_t;

  typedef struct packed {
    logic [7:0]        code;
    logic signed [8:0] offset;
    logic [1:0]        range;
    logic              bufPower;
    logic              bufToDac;
    logic              stageOn;
  } armd_dac_out_t;

endpackage : armd_pkg

// *** armd_result_mem.sv ***
`timescale 1ns/100ps
`default_nettype none

module armd_result_mem #(
  parameter int DEPTH = 8,
  parameter int WIDTH = 12
) (
  input  wire logic                     clk,
  input  wire logic                     resetn,
  input  wire logic                     we,
  input  wire logic [$clog2(DEPTH)-1:0] waddr,
  input  wire logic [WIDTH-1:0]         wdata,
  input  wire logic [$clog2(DEPTH)-1:0] raddr,
  output var  logic [WIDTH-1:0]         rdata
);

  logic [WIDTH-1:0] mem [DEPTH];

  // Cleared on reset so a channel never yet converted reads zero, not garbage
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < DEPTH; i++) mem[i] <= '0;
    end else if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Registered read; a read never sees a same-cycle write
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata <= '0;
    end else begin
      rdata <= mem[raddr];
    end
  end

endmodule : armd_result_mem

`default_nettype wire

// *** armd_top.sv ***
// Behaviour
// - Eight input channels; any selected subset converted one after another.
// - Single-pass mode stops after one loop; continuous mode repeats until a control write clears run.
// - Averaging loops sixteen times before giving one averaged result per channel.
// - Result registers update only when the whole cycle, averaging included, ends.
// - Results are 12-bit unsigned codes, zero to full scale 4095.
// - Each result is compared to its limit; violations raise readable warnings.
// - One limit per channel, acting as either minimum or maximum.
// - Loop starts from a bus write or a sequencing-engine enable.
// - Each selected channel takes 500 us; loop time scales with count.
// - Four independent margining DACs, each code written by the host.
// - Unsigned 8-bit DAC code, linear, 0x7F at the midcode voltage.
// - Each DAC has a four-way midcode range select.
// - Codes span 128 steps above midcode and 127 below.
// - On enable the buffer tracks the pin first, then switches and drives.
// - Applied DAC code is the written code clamped between lower and upper.
// - Lower clamp above upper clamp holds that DAC output in high impedance.
`timescale 1ns/100ps
`default_nettype none
`include "armd_defines.svh"

module armd_top #(
  parameter int CONV_CYCLES  = `ARMD_CONV_CYCLES,
  parameter int TRACK_CYCLES = `ARMD_TRACK_CYCLES
) (
  input  wire logic                          clk,
  input  wire logic                          resetn,
  input  wire logic                          hsel,
  input  wire logic [31:0]                   haddr,
  input  wire logic [1:0]                    htrans,
  input  wire logic                          hwrite,
  input  wire logic [2:0]                    hsize,
  input  wire logic [31:0]                   hwdata,
  input  wire logic                          hready,
  output var  logic                          hreadyout,
  output var  logic                          hresp,
  output var  logic [31:0]                   hrdata,
  output var  logic [2:0]                    adcChannel,
  output var  logic                          adcStart,
  input  wire logic [11:0]                   adcData,
  input  wire logic                          engineRunReq,
  output var  logic [7:0]                    engineWarn,
  output var  logic                          busy,
  output var  logic                          irq,
  output var  armd_pkg::armd_dac_out_t [3:0] dacOut
);
  import armd_pkg::*;

  localparam int TW = $clog2(CONV_CYCLES + 1);

  // First selected channel at or above 'from'; top bit says one was found
  function automatic logic [3:0] findSel(input logic [7:0] sel, input logic [3:0] from);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 7; i >= 0; i--) begin
      if (sel[i] && (4'(i) >= from)) r = {1'b1, 3'(i)};
    end
    return r;
  endfunction : findSel

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  armd_addr_phase_t addrPh_reg;
  logic             runEn_reg;
  logic             ctrlCont_reg;
  logic             ctrlAvg_reg;
  logic [7:0]       chanSel_reg;
  logic [7:0]       limDir_reg;
  logic [11:0]      limit_reg [8];
  logic [7:0]       warn_reg;
  logic [1:0]       irqStat_reg;
  logic [1:0]       irqMask_reg;
  logic [7:0]       dacCode_reg [4];
  armd_dac_cfg_t    dacCfg_reg [4];
  logic             engineRunPrev_reg;

  armd_seq_state_t  seqState_reg;
  logic [7:0]       selLatched_reg;
  logic             avgLatched_reg;
  logic [2:0]       chanIdx_reg;
  logic [3:0]       passCnt_reg;
  logic [TW-1:0]    timer_reg;
  logic [15:0]      acc_reg [8];
  logic [2:0]       pubIdx_reg;

  logic             wrEn;
  logic [7:0]       wa;
  logic             lastSlot;
  logic [3:0]       nextCh;
  logic [3:0]       firstCh;
  logic [3:0]       startCh;
  logic             pubLast;
  logic             memWe;
  logic [11:0]      pubValue;
  logic             pubWarn;
  logic             engineRise;
  logic [1:0]       irqSet;
  logic [11:0]      memRdata;

  // ----------------------------------------
  // AHB-Lite slave: zero wait states, always OKAY
  // ----------------------------------------
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      addrPh_reg <= '0;
    end else if (hready) begin
      addrPh_reg.valid <= hsel && htrans[1];
      addrPh_reg.write <= hwrite && (hsize == 3'h2);
      addrPh_reg.addr  <= haddr[7:0];
    end
  end

  assign wrEn = addrPh_reg.valid && addrPh_reg.write;
  assign wa   = addrPh_reg.addr;

  always_comb begin
    hrdata = 32'h0000_0000;
    if (addrPh_reg.valid && !addrPh_reg.write) begin
      if (wa == `ARMD_OFF_CTRL) begin
        hrdata[`ARMD_CTRL_RUN]  = runEn_reg;
        hrdata[`ARMD_CTRL_CONT] = ctrlCont_reg;
        hrdata[`ARMD_CTRL_AVG]  = ctrlAvg_reg;
      end else if (wa == `ARMD_OFF_CHSEL) begin
        hrdata[7:0] = chanSel_reg;
      end else if (wa == `ARMD_OFF_LIMDIR) begin
        hrdata[7:0] = limDir_reg;
      end else if (wa == `ARMD_OFF_STATUS) begin
        hrdata[7:0]             = warn_reg;
        hrdata[`ARMD_STAT_BUSY] = busy;
      end else if (wa == `ARMD_OFF_IRQSTAT) begin
        hrdata[1:0] = irqStat_reg;
      end else if (wa == `ARMD_OFF_IRQMASK) begin
        hrdata[1:0] = irqMask_reg;
      end else if ((wa & `ARMD_BANK8_MASK) == `ARMD_OFF_LIMIT) begin
        hrdata[11:0] = limit_reg[wa[4:2]];
      end else if ((wa & `ARMD_BANK8_MASK) == `ARMD_OFF_RESULT) begin
        hrdata[11:0] = memRdata;
      end else if ((wa & `ARMD_BANK4_MASK) == `ARMD_OFF_DACCODE) begin
        hrdata[7:0] = dacCode_reg[wa[3:2]];
      end else if ((wa & `ARMD_BANK4_MASK) == `ARMD_OFF_DACCFG) begin
        hrdata[`ARMD_CFG_RANGE +: 2] = dacCfg_reg[wa[3:2]].range;
        hrdata[`ARMD_CFG_EN]         = dacCfg_reg[wa[3:2]].en;
        hrdata[`ARMD_CFG_LO +: 8]    = dacCfg_reg[wa[3:2]].lower;
        hrdata[`ARMD_CFG_HI +: 8]    = dacCfg_reg[wa[3:2]].upper;
      end
    end
  end

  // ----------------------------------------
  // Host configuration
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrlCont_reg <= 1'b0;
      ctrlAvg_reg  <= 1'b0;
      chanSel_reg  <= 8'h00;
      limDir_reg   <= 8'h00;
      irqMask_reg  <= 2'h0;
      for (int i = 0; i < 8; i++) limit_reg[i] <= `ARMD_LIMIT_RST;
    end else if (wrEn) begin
      if (wa == `ARMD_OFF_CTRL) begin
        ctrlCont_reg <= hwdata[`ARMD_CTRL_CONT];
        ctrlAvg_reg  <= hwdata[`ARMD_CTRL_AVG];
      end
      if (wa == `ARMD_OFF_CHSEL) chanSel_reg <= hwdata[7:0];
      if (wa == `ARMD_OFF_LIMDIR) limDir_reg <= hwdata[7:0];
      if (wa == `ARMD_OFF_IRQMASK) irqMask_reg <= hwdata[1:0];
      if ((wa & `ARMD_BANK8_MASK) == `ARMD_OFF_LIMIT) begin
        limit_reg[wa[4:2]] <= hwdata[11:0];
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 4; i++) begin
        dacCode_reg[i] <= `ARMD_DAC_CODE_RST;
        dacCfg_reg[i]  <= '{upper: `ARMD_DAC_HI_RST, lower: `ARMD_DAC_LO_RST,
                            en: 1'b0, range: 2'h0};
      end
    end else if (wrEn) begin
      if ((wa & `ARMD_BANK4_MASK) == `ARMD_OFF_DACCODE) begin
        dacCode_reg[wa[3:2]] <= hwdata[7:0];
      end
      if ((wa & `ARMD_BANK4_MASK) == `ARMD_OFF_DACCFG) begin
        dacCfg_reg[wa[3:2]].range <= hwdata[`ARMD_CFG_RANGE +: 2];
        dacCfg_reg[wa[3:2]].en    <= hwdata[`ARMD_CFG_EN];
        dacCfg_reg[wa[3:2]].lower <= hwdata[`ARMD_CFG_LO +: 8];
        dacCfg_reg[wa[3:2]].upper <= hwdata[`ARMD_CFG_HI +: 8];
      end
    end
  end

  // ----------------------------------------
  // Run enable: bus write or engine request
  // ----------------------------------------
  assign engineRise = engineRunReq && !engineRunPrev_reg;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      engineRunPrev_reg <= 1'b0;
      runEn_reg         <= 1'b0;
    end else begin
      engineRunPrev_reg <= engineRunReq;
      // A start arriving with the single-pass stop still wins
      if ((wrEn && wa == `ARMD_OFF_CTRL && hwdata[`ARMD_CTRL_RUN]) || engineRise) begin
        runEn_reg <= 1'b1;
      end else if (wrEn && wa == `ARMD_OFF_CTRL) begin
        runEn_reg <= 1'b0;
      end else if (pubLast && !ctrlCont_reg) begin
        runEn_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Round-robin sequencer
  // ----------------------------------------
  assign lastSlot = timer_reg == TW'(CONV_CYCLES - 1);
  assign nextCh   = findSel(selLatched_reg, {1'b0, chanIdx_reg} + 4'h1);
  assign firstCh  = findSel(selLatched_reg, 4'h0);
  assign startCh  = findSel(chanSel_reg, 4'h0);
  assign pubLast  = (seqState_reg == SEQ_PUBLISH) && (pubIdx_reg == 3'h7);
  assign adcStart = (seqState_reg == SEQ_CONVERT) && (timer_reg == '0);
  assign busy     = seqState_reg != SEQ_IDLE;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      seqState_reg   <= SEQ_IDLE;
      selLatched_reg <= 8'h00;
      avgLatched_reg <= 1'b0;
      chanIdx_reg    <= 3'h0;
      passCnt_reg    <= 4'h0;
      timer_reg      <= '0;
      pubIdx_reg     <= 3'h0;
      for (int i = 0; i < 8; i++) acc_reg[i] <= 16'h0000;
    end else begin
      unique case (seqState_reg)
        SEQ_IDLE: begin
          if (runEn_reg && chanSel_reg != 8'h00) begin
            // Selection is frozen so a mid-loop rewrite cannot split a cycle
            selLatched_reg <= chanSel_reg;
            avgLatched_reg <= ctrlAvg_reg;
            chanIdx_reg    <= startCh[2:0];
            passCnt_reg    <= 4'h0;
            timer_reg      <= '0;
            for (int i = 0; i < 8; i++) acc_reg[i] <= 16'h0000;
            seqState_reg   <= SEQ_CONVERT;
          end
        end
        SEQ_CONVERT: begin
          timer_reg <= lastSlot ? '0 : timer_reg + 1'b1;
          if (lastSlot) begin
            acc_reg[chanIdx_reg] <= acc_reg[chanIdx_reg] + {4'h0, adcData};
            if (nextCh[3]) begin
              chanIdx_reg <= nextCh[2:0];
            end else if (avgLatched_reg && passCnt_reg != `ARMD_AVG_LAST_PASS) begin
              passCnt_reg <= passCnt_reg + 4'h1;
              chanIdx_reg <= firstCh[2:0];
            end else begin
              pubIdx_reg   <= 3'h0;
              seqState_reg <= SEQ_PUBLISH;
            end
          end
        end
        SEQ_PUBLISH: begin
          pubIdx_reg <= pubIdx_reg + 3'h1;
          // Always through idle; continuous mode restarts from there
          if (pubLast) seqState_reg <= SEQ_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      adcChannel <= 3'h0;
    end else if (seqState_reg == SEQ_IDLE) begin
      // Idle follows the live selection so the first slot of a new loop is right
      adcChannel <= startCh[2:0];
    end else begin
      adcChannel <= nextCh[3] ? nextCh[2:0] : firstCh[2:0];
    end
  end

  // ----------------------------------------
  // Publish results and limit warnings
  // ----------------------------------------
  assign memWe    = (seqState_reg == SEQ_PUBLISH) && selLatched_reg[pubIdx_reg];
  // Sum of sixteen 12-bit codes divided by sixteen stays within 12 bits
  assign pubValue = avgLatched_reg ? acc_reg[pubIdx_reg][15:4]
                                   : acc_reg[pubIdx_reg][11:0];
  assign pubWarn  = limDir_reg[pubIdx_reg] ? (pubValue > limit_reg[pubIdx_reg])
                                           : (pubValue < limit_reg[pubIdx_reg]);

  armd_result_mem #(
    .DEPTH (`ARMD_CHANNELS),
    .WIDTH (12)
  ) u_results (
    .clk    (clk),
    .resetn (resetn),
    .we     (memWe),
    .waddr  (pubIdx_reg),
    .wdata  (pubValue),
    .raddr  (haddr[4:2]),
    .rdata  (memRdata)
  );

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      warn_reg <= 8'h00;
    end else if (memWe) begin
      warn_reg[pubIdx_reg] <= pubWarn;
    end
  end

  assign engineWarn = warn_reg;

  // ----------------------------------------
  // Interrupts: sticky, write one to clear, set wins
  // ----------------------------------------
  assign irqSet[`ARMD_IRQ_DONE] = pubLast;
  assign irqSet[`ARMD_IRQ_WARN] = memWe && pubWarn && !warn_reg[pubIdx_reg];

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irqStat_reg <= 2'h0;
      irq         <= 1'b0;
    end else begin
      irqStat_reg <= (irqStat_reg & ~((wrEn && wa == `ARMD_OFF_IRQSTAT) ? hwdata[1:0] : 2'h0))
                     | irqSet;
      irq         <= |(irqStat_reg & irqMask_reg);
    end
  end

  // ----------------------------------------
  // Margining DACs
  // ----------------------------------------
  for (genvar d = 0; d < `ARMD_DACS; d++) begin : g_dac
    armd_dac_chan #(
      .TRACK_CYCLES (TRACK_CYCLES)
    ) u_dac (
      .clk    (clk),
      .resetn (resetn),
      .code   (dacCode_reg[d]),
      .cfg    (dacCfg_reg[d]),
      .dacOut (dacOut[d])
    );
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_publish_only_end: assert property (
    memWe |-> seqState_reg == SEQ_PUBLISH && $past(seqState_reg != SEQ_IDLE))
    else $error("result written outside publish");
  a_avg_sixteen: assert property (
    $rose(seqState_reg == SEQ_PUBLISH) && avgLatched_reg |-> passCnt_reg == 4'hF)
    else $error("averaged cycle ended before sixteen passes");
  a_slot_bound: assert property (
    seqState_reg == SEQ_CONVERT |-> timer_reg < TW'(CONV_CYCLES))
    else $error("conversion slot overran");
  a_single_stops: assert property (
    pubLast && !ctrlCont_reg && !wrEn && !engineRise |=> !runEn_reg ##1 seqState_reg == SEQ_IDLE)
    else $error("single pass did not stop");
  a_warn_to_irq: assert property (
    irqSet[`ARMD_IRQ_WARN] |=> irqStat_reg[`ARMD_IRQ_WARN] && warn_reg[$past(pubIdx_reg)])
    else $error("new warning not reported");

endmodule : armd_top

`default_nettype wire
